// file: rtl/oswu_regs.vh
// register offsets, field positions, reset values and counts for the oscillator control block
`ifndef OSWU_REGS_VH
`define OSWU_REGS_VH
`define OSWU_ADDR_W 4
`define OSWU_OFF_CTRL 4'h0
`define OSWU_OFF_IRQ_STAT 4'h4
`define OSWU_OFF_IRQ_MASK 4'h8
`define OSWU_CTRL_RESET 32'h80010030
`define OSWU_CTRL_RW_MASK 32'hFFFFCF08
`define OSWU_CTRL_RSVD_VAL 32'h00000030
`define OSWU_B_START 0
`define OSWU_B_ACTIVE 1
`define OSWU_B_SPEED_SEL 3
`define OSWU_B_EXT_HS_EN 8
`define OSWU_B_EXT_LS_EN 9
`define OSWU_B_LS_SEL 10
`define OSWU_B_HS_IN_EN 11
`define OSWU_B_CNT_LO_L 14
`define OSWU_B_CNT_LO_H 15
`define OSWU_B_INT_HS_EN 16
`define OSWU_B_HS_SEL 17
`define OSWU_B_PINS_USE 18
`define OSWU_B_WU_HS_SEL 19
`define OSWU_B_CNT_HI_L 20
`define OSWU_B_CNT_HI_H 31
`define OSWU_IRQ_DONE 0
`define OSWU_IRQ_START 1
`define OSWU_IRQ_W 2
`define OSWU_SYNC_STAGES 2
`endif

// file: rtl/oswu_edge_sync.v
// two-flop synchroniser with rising edge pulse for one oscillator clock
`timescale 1ns/1ns
module oswu_edge_sync (
    input wire clk,
    input wire rst_n,
    input wire async_in,
    output reg edge_pulse
);
    reg meta_q;
    reg sync_q;
    reg prev_q;
    // meta_q feeds only sync_q, everything else looks at sync_q
    always @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            edge_pulse <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
            edge_pulse <= sync_q & ~prev_q;
        end
    end
endmodule

// file: rtl/oswu_warmup_counter.v
// warm-up down counter advanced by one-cycle tick enables
`timescale 1ns/1ns
module oswu_warmup_counter #(
    parameter CNT_W = 16
) (
    input wire clk,
    input wire rst_n,
    input wire start,
    input wire [CNT_W-1:0] load_val,
    input wire tick,
    output reg active,
    output reg done_pulse
);
    reg [CNT_W-1:0] cnt_q;
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= {CNT_W{1'b0}};
            active <= 1'b0;
            done_pulse <= 1'b0;
        end else begin
            done_pulse <= 1'b0;
            if (start) begin
                // a restart while counting reloads; a zero count ends at the next tick
                cnt_q <= load_val;
                active <= 1'b1;
            end else if (active && tick) begin
                if (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    cnt_q <= {CNT_W{1'b0}};
                    active <= 1'b0;
                    done_pulse <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// file: rtl/oswu_osc_ctrl.v
// oscillator select and warm-up timer control, top module
// Contract
// - bit 17 picks high-speed source: 0 internal, 1 external oscillator.
// - bit 16 runs internal high-speed oscillator when 1, stops when 0.
// - external high-speed clock input accepted only while bit 11 is 1.
// - low-speed clock: bit 10 0 crystal oscillator, 1 input pin.
// - bit 9 keeps external low-speed oscillator running, else stopped.
// - bit 8 keeps external high-speed oscillator running, else stopped.
// - bit 3 clocks warm-up from high-speed (0) or low-speed (1) clock.
// - high-speed warm-up uses bit 19 selector; low-speed uses bit 10.
// - read-only bit 1 reads 1 while warm-up counts, 0 when done.
// - writing 1 to bit 0 starts warm-up; bit reads 0 always.
// - external high-speed clock input never clocks the warm-up timer.
// - warm-up count is bits 31-20, then two zero bits, then the low two count bits.
// - bit 19 picks high-speed warm-up clock: 0 internal, 1 external.
// - external high-speed crystal pins used only while bit 18 is 1.
`timescale 1ns/1ns
`include "oswu_regs.vh"
module oswu_osc_ctrl #(
    parameter CNT_W = 16
) (
    input wire MCLK,
    input wire RESETN,
    input wire [`OSWU_ADDR_W-1:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    input wire INT_HS_OSC_CLK,
    input wire EXT_HS_OSC_CLK,
    input wire EXT_LS_OSC_CLK,
    input wire EXT_LS_INPUT_CLK,
    input wire EXT_HS_INPUT_CLK,
    output reg INT_HS_OSC_EN,
    output reg EXT_HS_OSC_EN,
    output reg EXT_LS_OSC_EN,
    output reg EXT_HS_PINS_USE,
    output reg EXT_HS_INPUT_EN,
    output reg HS_SEL_EXT,
    output reg LS_SEL_INPUT,
    output reg HS_CLK_TICK,
    output reg LS_CLK_TICK,
    output reg WARMUP_ACTIVE,
    output reg IRQ
);
    reg [31:0] ctrl_q;
    reg [31:0] ctrl_d;
    reg [`OSWU_IRQ_W-1:0] stat_q;
    reg [`OSWU_IRQ_W-1:0] stat_d;
    reg [`OSWU_IRQ_W-1:0] mask_q;
    reg start_q;
    wire wu_active;
    wire wu_done;
    wire [4:0] osc_edge;
    wire [4:0] osc_raw;
    reg hs_tick;
    reg ls_tick;
    reg wu_tick;
    wire [CNT_W-1:0] wu_count;

    function is_addr;
        input [`OSWU_ADDR_W-1:0] a;
        input [`OSWU_ADDR_W-1:0] off;
        begin
            is_addr = (a == off);
        end
    endfunction

    // each oscillator edge crosses into MCLK; its frequency must stay under MCLK/4
    assign osc_raw = {EXT_HS_INPUT_CLK, EXT_LS_INPUT_CLK, EXT_LS_OSC_CLK,
                      EXT_HS_OSC_CLK, INT_HS_OSC_CLK};
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
            oswu_edge_sync u_sync (
                .clk(MCLK),
                .rst_n(RESETN),
                .async_in(osc_raw[gi]),
                .edge_pulse(osc_edge[gi])
            );
        end
    endgenerate

    // tick enables from the selected and gated sources
    always @* begin
        hs_tick = ctrl_q[`OSWU_B_HS_SEL] ?
            (osc_edge[1] & ctrl_q[`OSWU_B_EXT_HS_EN] & ctrl_q[`OSWU_B_PINS_USE]) |
            (osc_edge[4] & ctrl_q[`OSWU_B_HS_IN_EN]) :
            (osc_edge[0] & ctrl_q[`OSWU_B_INT_HS_EN]);
        ls_tick = ctrl_q[`OSWU_B_LS_SEL] ? osc_edge[3] :
            (osc_edge[2] & ctrl_q[`OSWU_B_EXT_LS_EN]);
        if (ctrl_q[`OSWU_B_SPEED_SEL]) begin
            wu_tick = ls_tick;
        end else if (ctrl_q[`OSWU_B_WU_HS_SEL]) begin
            // crystal edges only; the external clock input is left out on purpose
            wu_tick = osc_edge[1] & ctrl_q[`OSWU_B_EXT_HS_EN] & ctrl_q[`OSWU_B_PINS_USE];
        end else begin
            wu_tick = osc_edge[0] & ctrl_q[`OSWU_B_INT_HS_EN];
        end
    end

    assign wu_count = {ctrl_q[`OSWU_B_CNT_HI_H:`OSWU_B_CNT_HI_L],
                       {(CNT_W-14){1'b0}},
                       ctrl_q[`OSWU_B_CNT_LO_H:`OSWU_B_CNT_LO_L]};

    oswu_warmup_counter #(
        .CNT_W(CNT_W)
    ) u_wu (
        .clk(MCLK),
        .rst_n(RESETN),
        .start(start_q),
        .load_val(wu_count),
        .tick(wu_tick),
        .active(wu_active),
        .done_pulse(wu_done)
    );

    // register writes; reserved fields keep their fixed pattern whatever is written
    always @* begin
        ctrl_d = ctrl_q;
        if (WR && is_addr(ADDR, `OSWU_OFF_CTRL)) begin
            ctrl_d = (WDATA & `OSWU_CTRL_RW_MASK) | `OSWU_CTRL_RSVD_VAL;
        end
        // set wins over a same-cycle clear
        stat_d = stat_q;
        if (WR && is_addr(ADDR, `OSWU_OFF_IRQ_STAT)) begin
            stat_d = stat_q & ~WDATA[`OSWU_IRQ_W-1:0];
        end
        stat_d = stat_d | {start_q, wu_done};
    end

    always @(posedge MCLK) begin
        if (!RESETN) begin
            ctrl_q <= `OSWU_CTRL_RESET;
            stat_q <= {`OSWU_IRQ_W{1'b0}};
            mask_q <= {`OSWU_IRQ_W{1'b0}};
            start_q <= 1'b0;
            RDATA <= 32'h00000000;
        end else begin
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            start_q <= WR && is_addr(ADDR, `OSWU_OFF_CTRL) && WDATA[`OSWU_B_START];
            if (WR && is_addr(ADDR, `OSWU_OFF_IRQ_MASK)) begin
                mask_q <= WDATA[`OSWU_IRQ_W-1:0];
            end
            RDATA <= 32'h00000000;
            if (RD) begin
                if (is_addr(ADDR, `OSWU_OFF_CTRL)) begin
                    RDATA <= ctrl_q | {30'h00000000, wu_active | start_q, 1'b0};
                end else if (is_addr(ADDR, `OSWU_OFF_IRQ_STAT)) begin
                    RDATA <= {{(32-`OSWU_IRQ_W){1'b0}}, stat_q};
                end else if (is_addr(ADDR, `OSWU_OFF_IRQ_MASK)) begin
                    RDATA <= {{(32-`OSWU_IRQ_W){1'b0}}, mask_q};
                end
            end
        end
    end

    always @(posedge MCLK) begin
        if (!RESETN) begin
            INT_HS_OSC_EN <= 1'b1;
            EXT_HS_OSC_EN <= 1'b0;
            EXT_LS_OSC_EN <= 1'b0;
            EXT_HS_PINS_USE <= 1'b0;
            EXT_HS_INPUT_EN <= 1'b0;
            HS_SEL_EXT <= 1'b0;
            LS_SEL_INPUT <= 1'b0;
            HS_CLK_TICK <= 1'b0;
            LS_CLK_TICK <= 1'b0;
            WARMUP_ACTIVE <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            INT_HS_OSC_EN <= ctrl_d[`OSWU_B_INT_HS_EN];
            EXT_HS_OSC_EN <= ctrl_d[`OSWU_B_EXT_HS_EN];
            EXT_LS_OSC_EN <= ctrl_d[`OSWU_B_EXT_LS_EN];
            EXT_HS_PINS_USE <= ctrl_d[`OSWU_B_PINS_USE];
            EXT_HS_INPUT_EN <= ctrl_d[`OSWU_B_HS_IN_EN];
            HS_SEL_EXT <= ctrl_d[`OSWU_B_HS_SEL];
            LS_SEL_INPUT <= ctrl_d[`OSWU_B_LS_SEL];
            HS_CLK_TICK <= hs_tick;
            LS_CLK_TICK <= ls_tick;
            WARMUP_ACTIVE <= wu_active | start_q;
            IRQ <= |(stat_d & mask_q);
        end
    end
endmodule

// file: testbench/oswu_osc_ctrl_monitor.sv
// assertion checker on the oscillator control top ports
`timescale 1ns/1ns
`include "oswu_regs.vh"
module oswu_osc_ctrl_monitor (
    input wire MCLK,
    input wire RESETN,
    input wire [`OSWU_ADDR_W-1:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [31:0] RDATA,
    input wire INT_HS_OSC_EN,
    input wire EXT_HS_OSC_EN,
    input wire EXT_LS_OSC_EN,
    input wire EXT_HS_PINS_USE,
    input wire EXT_HS_INPUT_EN,
    input wire HS_SEL_EXT,
    input wire LS_SEL_INPUT,
    input wire WARMUP_ACTIVE
);
    // control write, the only cause allowed to move an enable
    wire wc = WR && ADDR == `OSWU_OFF_CTRL;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    a_hs_source_sel: assert property (wc |=> HS_SEL_EXT == $past(WDATA[17]))
        else $error("hs source select wrong");
    a_int_osc_run: assert property (wc |=> INT_HS_OSC_EN == $past(WDATA[16]))
        else $error("internal osc enable wrong");
    a_int_osc_steady: assert property (!wc |=> $stable(INT_HS_OSC_EN))
        else $error("internal osc enable moved without write");
    a_hs_input_gate: assert property (wc |=> EXT_HS_INPUT_EN == $past(WDATA[11]))
        else $error("hs input enable wrong");
    a_ls_source_sel: assert property (wc |=> LS_SEL_INPUT == $past(WDATA[10]))
        else $error("ls source select wrong");
    a_ls_osc_run: assert property (wc |=> EXT_LS_OSC_EN == $past(WDATA[9]))
        else $error("ls osc enable wrong");
    a_hs_osc_run: assert property (wc |=> EXT_HS_OSC_EN == $past(WDATA[8]))
        else $error("hs osc enable wrong");
    a_pins_use_bit: assert property (wc |=> EXT_HS_PINS_USE == $past(WDATA[18]))
        else $error("crystal pin use wrong");
    a_start_runs_timer: assert property (wc && WDATA[0] |-> ##[1:3] WARMUP_ACTIVE)
        else $error("start did not run warm-up");
    a_start_reads_zero: assert property (RD && ADDR == 4'h0 |=> !RDATA[0])
        else $error("start bit read as one");
endmodule

// file: testbench/oswu_osc_ctrl_tb.sv
// self-checking bench for the oscillator control block
`timescale 1ns/1ns
module oswu_osc_ctrl_tb;
    reg MCLK = 0, RESETN = 0, WR = 0, RD = 0, ls_clk = 0, ls_run = 0, rd_d = 0;
    reg [3:0] ADDR = 4'h0;
    reg [31:0] WDATA = 32'h0, w;
    wire [31:0] RDATA;
    wire INT_HS_OSC_EN, EXT_HS_OSC_EN, EXT_LS_OSC_EN, EXT_HS_PINS_USE, EXT_HS_INPUT_EN;
    wire HS_SEL_EXT, LS_SEL_INPUT, HS_CLK_TICK, LS_CLK_TICK, WARMUP_ACTIVE, IRQ;
    integer err_total = 0, checks = 0, seed = 32'hF03B68D7, i, n;
    reg [31:0] exp_q[$];
    oswu_osc_ctrl oswu_osc_ctrl_inst (.MCLK(MCLK), .RESETN(RESETN), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .INT_HS_OSC_CLK(1'b0),
        .EXT_HS_OSC_CLK(1'b0), .EXT_LS_OSC_CLK(ls_clk), .EXT_LS_INPUT_CLK(1'b0),
        .EXT_HS_INPUT_CLK(ls_clk), .INT_HS_OSC_EN(INT_HS_OSC_EN), .EXT_HS_OSC_EN(EXT_HS_OSC_EN),
        .EXT_LS_OSC_EN(EXT_LS_OSC_EN), .EXT_HS_PINS_USE(EXT_HS_PINS_USE),
        .EXT_HS_INPUT_EN(EXT_HS_INPUT_EN), .HS_SEL_EXT(HS_SEL_EXT), .LS_SEL_INPUT(LS_SEL_INPUT),
        .HS_CLK_TICK(HS_CLK_TICK), .LS_CLK_TICK(LS_CLK_TICK), .WARMUP_ACTIVE(WARMUP_ACTIVE),
        .IRQ(IRQ));
    always #2 MCLK = ~MCLK;
    // slow crystal, well under a quarter of the system clock so every edge is seen
    always #16 if (ls_run) ls_clk = ~ls_clk;
    task chk(input [31:0] s, input [31:0] e);
        begin
            checks = checks + 1;
            if (s !== e) begin
                err_total = err_total + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
            end
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge MCLK);
            ADDR <= a;
            WDATA <= d;
            WR <= 1'b1;
            @(posedge MCLK);
            WR <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [31:0] e);
        begin
            @(posedge MCLK);
            ADDR <= a;
            RD <= 1'b1;
            exp_q.push_back(e);
            @(posedge MCLK);
            RD <= 1'b0;
        end
    endtask
    task tally_and_finish;
        begin
            if (err_total == 0 && checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge MCLK) begin
        if (rd_d) chk(RDATA, exp_q.pop_front());
        rd_d <= RD;
    end
    initial begin
        repeat (6) @(posedge MCLK);
        RESETN <= 1'b1;
        rd(4'h0, 32'h80010030);
        chk(INT_HS_OSC_EN, 32'h1);
        for (i = 0; i < 8; i = i + 1) begin
            w = $random(seed) & 32'hFFFF0F08 | 32'h30;
            if (!w[3]) w[15:14] = 2'h0;
            wr(4'h0, w);
            rd(4'h0, w);
            chk({HS_SEL_EXT, INT_HS_OSC_EN, EXT_HS_INPUT_EN, LS_SEL_INPUT, EXT_LS_OSC_EN,
                EXT_HS_OSC_EN, EXT_HS_PINS_USE}, {w[17:16], w[11:8], w[18]});
        end
        wr(4'hC, 32'hFFFFFFFF);
        rd(4'hC, 32'h0);
        rd(4'h0, w);
        // low-speed crystal warm-up, count 16 from the high field plus 2 from the low
        w = 32'h00108238;
        wr(4'h8, 32'h1);
        wr(4'h0, w | 32'h1);
        rd(4'h0, w | 32'h2);
        ls_run = 1'b1;
        n = 0;
        for (i = 0; i < 400 && WARMUP_ACTIVE; i = i + 1) begin
            @(posedge MCLK);
            #1;
            n = n + LS_CLK_TICK;
        end
        ls_run = 1'b0;
        if (i == 400) begin
            err_total = err_total + 1;
            tally_and_finish;
        end
        chk(n, 32'd18);
        rd(4'h4, 32'h3);
        chk(IRQ, 32'h1);
        wr(4'h8, 32'h0);
        rd(4'h0, w);
        chk(IRQ, 32'h0);
        wr(4'h4, 32'h3);
        wr(4'h8, 32'h1);
        rd(4'h4, 32'h0);
        chk(IRQ, 32'h0);
        // external source with internal stopped; of the high-speed sources only the input pin toggles
        wr(4'h0, 32'h001E0931);
        ls_run = 1'b1;
        n = 0;
        for (i = 0; i < 100; i = i + 1) begin
            @(posedge MCLK);
            #1;
            n = n + HS_CLK_TICK;
        end
        ls_run = 1'b0;
        chk(n > 0, 32'h1);
        chk(WARMUP_ACTIVE, 32'h1);
        repeat (2) @(posedge MCLK);
        tally_and_finish;
    end
endmodule
bind oswu_osc_ctrl oswu_osc_ctrl_monitor oswu_osc_ctrl_monitor_inst (.MCLK(MCLK),
    .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .INT_HS_OSC_EN(INT_HS_OSC_EN), .EXT_HS_OSC_EN(EXT_HS_OSC_EN), .EXT_LS_OSC_EN(EXT_LS_OSC_EN),
    .EXT_HS_PINS_USE(EXT_HS_PINS_USE), .EXT_HS_INPUT_EN(EXT_HS_INPUT_EN),
    .HS_SEL_EXT(HS_SEL_EXT), .LS_SEL_INPUT(LS_SEL_INPUT), .WARMUP_ACTIVE(WARMUP_ACTIVE));
